// [inc/asc_pkg.sv]
// Package for the ADC conversion sequencer: timing counts, enums and carriers.
// Assumes a 100 MHz system clock and a 12-bit successive-approximation core outside.
package asc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int NCH = 16;
    localparam int DW = 12;
    // Times in nanoseconds, as printed.
    localparam int T_CONV_NS = 1625;
    localparam int T_ACQ0_NS = 375;
    localparam int T_ACQ1_NS = 2375;
    localparam int T_ACQ2_NS = 6375;
    localparam int T_ACQ3_NS = 14375;
    localparam int T_SYNC_NS = 4000;
    localparam int T_DAV_NS = 1000;
    // Least times round up, longest times round down.
    localparam int CYC_CONV = (T_CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_ACQ0 = (T_ACQ0_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_ACQ1 = (T_ACQ1_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_ACQ2 = (T_ACQ2_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_ACQ3 = (T_ACQ3_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_SYNC = (T_SYNC_NS * CLK_MHZ) / 1000;
    localparam int CYC_DAV = (T_DAV_NS * CLK_MHZ + 999) / 1000;
    localparam int CW = 12;
    // Sync delay actually used, well inside the longest allowed.
    localparam logic [CW-1:0] SYNC_CNT = 12'h004;
    localparam logic [1:0] RATE_FAST = 2'h0;
    localparam logic [DW-1:0] RESULT_RST = 12'h000;
    localparam logic [NCH-1:0] DIFF_MASK = 16'h000f;

    typedef enum logic [5:0] {
        ASC_IDLE = 6'h01,
        ASC_SYNC = 6'h02,
        ASC_ACQ = 6'h04,
        ASC_CONV = 6'h08,
        ASC_NAP = 6'h10,
        ASC_DONE = 6'h20
    } asc_state_t;

    // Configuration as written by the host, with its write strobes.
    typedef struct packed {
        logic conversion_mode_bit;
        logic [1:0] rate_select_field;
        logic [NCH-1:0] chan_sel;
        logic [1:0] diff_pair;
    } asc_cfg_t;

    typedef struct packed {
        logic cfg_wr;
        logic internal_convert_bit;
        logic chan_sel_wr;
        logic thresh_wr;
    } asc_wr_t;
endpackage : asc_pkg

// [design/asc_sequencer.sv]
// Conversion sequencer for a 16-channel multiplexed SAR ADC with double-buffered results.
// Assumes all inputs synchronous to mclk_i; the SAR core answers with a done pulse.
//
// Summary of operation
// - Start on trigger pin fall or convert bit
// - New trigger aborts and restarts from first channel
// - Direct mode converts each selected channel once
// - Auto mode repeats selected channels ascending forever
// - Mode change or selection or threshold write halts
// - Convert bit with mode change returns idle
// - Channel result copied into its holding register
// - Last channel moves all holding values out
// - Result update waits while shift-out busy
// - Single-ended binary, differential twos complement
// - Rate field sets acquisition time per conversion
// - Nap between conversions unless rate is fastest
// - Per-channel rate is rate over channel count
// - Up to 4 us sync after trigger
// - Direct mode done sets flag, pin low
// - Direct mode flag clears on read or pin
// - Auto mode pass gives 1 us low pulse
// - Pin trigger aborts at once, as with
// - Out-of-range flags and global alarm pin low
module asc_sequencer
    import asc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic convert_trigger_pin_i,
    input wire asc_pkg::asc_cfg_t cfg_i,
    input wire asc_pkg::asc_wr_t wr_i,
    input wire logic result_read_i,
    input wire logic [3:0] result_addr_i,
    input wire logic shift_busy_i,
    input wire logic [11:0] sar_data_i,
    input wire logic sar_done_i,
    input wire logic [5:0] range_fault_i,
    output logic [3:0] mux_sel_o,
    output logic sar_start_o,
    output logic sar_diff_o,
    output logic nap_o,
    output logic [11:0] result_o,
    output logic data_available_flag_o,
    output logic data_available_pin_n_o,
    output logic [5:0] alarm_flags_o,
    output logic alarm_n_o
);
    import asc_pkg::*;

    logic [1:0] rst_sync;
    logic rst_n;
    asc_state_t state;
    asc_state_t next_state;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [3:0] chan;
    logic [3:0] next_chan;
    logic pin_q;
    logic [DW-1:0] hold [NCH];
    logic [DW-1:0] result [NCH];
    logic xfer_pend;
    logic [CW-1:0] dav_cnt;
    logic dav_flag;
    logic mode_q;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Trigger detection and halting conditions.
    wire pin_fall = pin_q && !convert_trigger_pin_i;
    wire trig = pin_fall || wr_i.internal_convert_bit;
    wire mode_chg = wr_i.cfg_wr && (cfg_i.conversion_mode_bit != mode_q);
    wire halt = mode_chg || wr_i.chan_sel_wr || wr_i.thresh_wr;
    wire cancel = halt && wr_i.internal_convert_bit;
    wire none_sel = (cfg_i.chan_sel == 16'h0000);

    // Lowest selected channel at or above a start point, by a priority scan.
    function automatic logic [4:0] find_from(input logic [NCH-1:0] sel, input logic [4:0] from);
        logic [4:0] r;
        r = 5'h10;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (sel[i] && (5'(i) >= from))
                r = 5'(i);
        end
        return r;
    endfunction : find_from

    wire [4:0] first_ch = find_from(cfg_i.chan_sel, 5'h00);
    wire [4:0] next_ch = find_from(cfg_i.chan_sel, {1'b0, chan} + 5'h01);
    wire last_ch = next_ch[4];
    wire [CW-1:0] acq_cyc =
        (cfg_i.rate_select_field == 2'h0) ? CW'(CYC_ACQ0) :
        (cfg_i.rate_select_field == 2'h1) ? CW'(CYC_ACQ1) :
        (cfg_i.rate_select_field == 2'h2) ? CW'(CYC_ACQ2) : CW'(CYC_ACQ3);
    wire is_diff = DIFF_MASK[chan] && cfg_i.diff_pair[chan[1]];

    always_comb
    begin
        next_state = state;
        next_cnt = (cnt != '0) ? cnt - CW'(1) : cnt;
        next_chan = chan;
        case (state)
            ASC_IDLE:
                next_cnt = '0;
            ASC_SYNC:
                if (cnt == '0)
                begin
                    next_state = ASC_ACQ;
                    next_chan = first_ch[3:0];
                    next_cnt = acq_cyc - CW'(1);
                end
            ASC_ACQ:
                if (cnt == '0)
                begin
                    next_state = ASC_CONV;
                    next_cnt = CW'(CYC_CONV);
                end
            ASC_CONV:
                if (sar_done_i)
                begin
                    if (!last_ch)
                    begin
                        next_chan = next_ch[3:0];
                        next_state = (cfg_i.rate_select_field != RATE_FAST) ? ASC_NAP : ASC_ACQ;
                        next_cnt = acq_cyc - CW'(1);
                    end
                    else
                        next_state = ASC_DONE;
                end
            ASC_NAP:
                if (cnt == '0)
                begin
                    next_state = ASC_CONV;
                    next_cnt = CW'(CYC_CONV);
                end
            ASC_DONE:
                if (!xfer_pend || !shift_busy_i)
                begin
                    if (mode_q)
                    begin
                        next_state = (cfg_i.rate_select_field != RATE_FAST) ? ASC_NAP : ASC_ACQ;
                        next_chan = first_ch[3:0];
                        next_cnt = acq_cyc - CW'(1);
                    end
                    else
                        next_state = ASC_IDLE;
                end
            default:
                next_state = ASC_IDLE;
        endcase
        // New triggers abort at once, pin triggers included; halts win.
        if (trig && !none_sel)
        begin
            next_state = ASC_SYNC;
            next_cnt = SYNC_CNT;
        end
        if (halt)
            next_state = ASC_IDLE;
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ASC_IDLE;
            cnt <= '0;
            chan <= 4'h0;
            pin_q <= 1'b1;
            mode_q <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            chan <= next_chan;
            pin_q <= convert_trigger_pin_i;
            if (wr_i.cfg_wr)
                mode_q <= cfg_i.conversion_mode_bit;
        end
    end

    // Two-stage result buffer.
    wire capture = (state == ASC_CONV) && sar_done_i && !trig && !halt;
    wire [DW-1:0] coded = is_diff ? {~sar_data_i[DW-1], sar_data_i[DW-2:0]} : sar_data_i;
    wire pass_end = capture && last_ch;
    wire move = (pass_end || xfer_pend) && !shift_busy_i;

    generate
        for (genvar g = 0; g < NCH; g++)
        begin : g_buf
            always_ff @(posedge mclk_i or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    hold[g] <= RESULT_RST;
                    result[g] <= RESULT_RST;
                end
                else
                begin
                    if (capture && (chan == 4'(g)))
                        hold[g] <= coded;
                    if (move)
                        result[g] <= (pass_end && (chan == 4'(g))) ? coded : hold[g];
                end
            end
        end
    endgenerate

    // Data-available handshake and outputs.
    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xfer_pend <= 1'b0;
            dav_flag <= 1'b0;
            dav_cnt <= '0;
            data_available_pin_n_o <= 1'b1;
            data_available_flag_o <= 1'b0;
            result_o <= RESULT_RST;
            mux_sel_o <= 4'h0;
            sar_start_o <= 1'b0;
            sar_diff_o <= 1'b0;
            nap_o <= 1'b0;
            alarm_flags_o <= 6'h00;
            alarm_n_o <= 1'b1;
        end
        else
        begin
            xfer_pend <= (pass_end || xfer_pend) && shift_busy_i && !trig && !halt;
            if (move && !mode_q)
                dav_flag <= 1'b1;
            else if (result_read_i || pin_fall || mode_q)
                dav_flag <= 1'b0;
            if (move && mode_q)
                dav_cnt <= CW'(CYC_DAV);
            else if (dav_cnt != '0)
                dav_cnt <= dav_cnt - CW'(1);
            data_available_flag_o <= (move && !mode_q) || (dav_flag && !mode_q
                && !result_read_i && !pin_fall);
            data_available_pin_n_o <= !(((move && !mode_q) || (dav_flag && !mode_q
                && !result_read_i && !pin_fall)) || (move && mode_q) || (dav_cnt > CW'(1)));
            result_o <= result[result_addr_i];
            mux_sel_o <= chan;
            sar_start_o <= (next_state == ASC_CONV) && (state != ASC_CONV);
            sar_diff_o <= is_diff;
            nap_o <= (state == ASC_NAP);
            alarm_flags_o <= range_fault_i;
            alarm_n_o <= !(|range_fault_i);
        end
    end

    sequence trig_s;
        trig && !none_sel && !halt;
    endsequence

    trig_restart_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        trig_s |=> state == ASC_SYNC)
        else $error("trigger did not restart the sequence");
    halt_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        halt |=> state == ASC_IDLE)
        else $error("halt did not stop conversion");
    cancel_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        cancel |=> state == ASC_IDLE && sar_start_o == 1'b0)
        else $error("convert with mode change not cancelled");
    hold_cap_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        capture |=> hold[$past(chan)] == $past(coded))
        else $error("holding register missed result");
    busy_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        shift_busy_i |=> $stable(result[0]) && $stable(result[15]))
        else $error("results changed during shift-out");
    direct_dav_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        move && !mode_q && !halt |=> data_available_flag_o && !data_available_pin_n_o)
        else $error("direct mode data-available not raised");
    read_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        dav_flag && result_read_i && !move |=> !data_available_flag_o)
        else $error("read did not clear data-available");
    auto_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        move && mode_q && !wr_i.cfg_wr |=> !data_available_pin_n_o [*8] ##93
            data_available_pin_n_o)
        else $error("auto mode pulse has wrong length");
    nap_fast_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        cfg_i.rate_select_field == RATE_FAST && state != ASC_NAP |=> !nap_o)
        else $error("nap used at fastest rate");
    alarm_pin_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        |range_fault_i |=> !alarm_n_o)
        else $error("alarm pin not driven low");
endmodule : asc_sequencer

// [bench/asc_sar_model.sv]
// Behavioural SAR core that answers each start pulse after lat_i + 1 cycles.
// Assumes start_i is a one-cycle pulse; a new start restarts the conversion.
module asc_sar_model
(
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [3:0] mux_i,
    input wire logic [7:0] lat_i,
    output logic [11:0] data_o,
    output logic done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'h00;
    logic [3:0] ch = 4'h0;
    initial data_o = 12'h000;
    initial done_o = 1'b0;
    // Data outside the done pulse flips every cycle so stale values never match.
    always_ff @(posedge clk_i)
    begin
        done_o <= 1'b0;
        data_o <= ~data_o;
        if (start_i)
        begin
            cnt <= lat_i + 8'h01;
            ch <= mux_i;
        end
        else if (cnt != 8'h00)
        begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01)
            begin
                done_o <= 1'b1;
                data_o <= {ch, ~ch, ch};
            end
        end
    end
endmodule : asc_sar_model

// [bench/adc_sequence_control_test.sv]
// Self-checking bench for the conversion sequencer with a SAR core model.
// Assumes inputs change at the falling clock edge and the package timing counts.
module adc_sequence_control_test;
    import asc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, pin, rd, busy, start, diff, nap, sdone, flag, pin_n, alarm_n;
    logic [3:0] addr, mux;
    logic [5:0] fault, aflags;
    logic [11:0] sdata, res;
    logic [7:0] lat;
    logic [31:0] seed;
    logic [3:0] q[$];
    asc_cfg_t cfg;
    asc_wr_t wr;
    int error_cnt, checks, i, j, n;
    int acq[4] = '{CYC_ACQ0, CYC_ACQ1, CYC_ACQ2, CYC_ACQ3};
    int seq[3] = '{0, 4, 15};
    logic [3:0] hw[4] = '{4'h8, 4'h2, 4'h1, 4'hc};

    asc_sequencer u_dut (.mclk_i(clk), .nrst_i(nrst), .convert_trigger_pin_i(pin),
        .cfg_i(cfg), .wr_i(wr), .result_read_i(rd), .result_addr_i(addr),
        .shift_busy_i(busy), .sar_data_i(sdata), .sar_done_i(sdone),
        .range_fault_i(fault), .mux_sel_o(mux), .sar_start_o(start), .sar_diff_o(diff),
        .nap_o(nap), .result_o(res), .data_available_flag_o(flag),
        .data_available_pin_n_o(pin_n), .alarm_flags_o(aflags), .alarm_n_o(alarm_n));
    asc_sar_model u_sar (.clk_i(clk), .start_i(start), .mux_i(mux), .lat_i(lat),
        .data_o(sdata), .done_o(sdone));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (start === 1'b1)
            q.push_back(mux);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [11:0] expv(logic [3:0] ch);
        logic [11:0] v;
        v = {ch, ~ch, ch};
        if (ch < 4 && cfg.diff_pair[ch[1]])
            v[11] = ~v[11];
        return v;
    endfunction : expv
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    task automatic strobe(input asc_wr_t w);
        @(negedge clk);
        wr = w;
        @(negedge clk);
        wr = '0;
    endtask : strobe
    task automatic pinfall();
        @(negedge clk);
        pin = 1'b0;
        @(negedge clk);
        pin = 1'b1;
    endtask : pinfall
    task automatic hostrd();
        @(negedge clk);
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
    endtask : hostrd
    task automatic wstart(input int k);
        for (i = 0; i < 8000 && q.size() < k; i++)
            @(negedge clk);
    endtask : wstart
    task automatic meas(input int from);
        for (j = from; j < 3000 && start !== 1'b1; j++)
            @(negedge clk);
    endtask : meas
    task automatic finish_test();
        if (error_cnt == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    initial
    begin
        #500000;
        error_cnt++;
        finish_test();
    end

    initial
    begin
        {nrst, rd, busy, addr, fault, lat, cfg, wr, error_cnt, checks} = '0;
        pin = 1'b1;
        seed = 67;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        tick(3);
        // Direct passes over random channel sets while shift-out is busy.
        for (n = 0; n < 2; n++)
        begin
            cfg.chan_sel = 16'(rnd()) | 16'h0001;
            cfg.diff_pair = 2'(rnd());
            lat = 8'(rnd() & 31);
            busy = 1'b1;
            q.delete();
            strobe(4'h4);
            wstart($countones(cfg.chan_sel));
            tick(100);
            cmp(flag, 0);
            busy = 1'b0;
            tick(3);
            cmp({flag, pin_n}, 2'b10);
            j = 0;
            for (i = 0; i < 16; i++)
                if (cfg.chan_sel[i])
                begin
                    cmp(q[j], i);
                    addr = 4'(i);
                    tick(2);
                    cmp(res, expv(addr));
                    j++;
                end
            cmp(q.size(), j);
            hostrd();
            cmp({flag, pin_n}, 2'b01);
        end
        // Trigger to first start for each rate code, nap checked in acquisition.
        cfg.chan_sel = 16'h0003;
        for (n = 0; n < 4; n++)
        begin
            cfg.rate_select_field = 2'(n);
            strobe(4'h8);
            strobe(4'h4);
            tick(15);
            meas(16);
            cmp(16'(j), 16'(acq[n] + 6));
            tick(40);
            cmp(nap, n != 0);
            tick(20);
            hostrd();
        end
        cfg = '{1'b1, 2'h0, 16'h8011, 2'h0};
        lat = 8'h3c;
        strobe(4'ha);
        q.delete();
        pinfall();
        for (j = 0; j < 3000 && pin_n !== 1'b0; j++)
            @(negedge clk);
        cmp(flag, 0);
        for (j = 0; j < 300 && pin_n === 1'b0; j++)
            @(negedge clk);
        cmp(16'(j), 16'(CYC_DAV));
        wstart(8);
        for (j = 0; j < 8; j++)
            cmp(q[j], 16'(seq[j % 3]));
        // Trigger during a slow conversion restarts at the first channel at once.
        pinfall();
        n = q.size();
        meas(1);
        wstart(n + 1);
        cmp(16'(j), 16'(CYC_ACQ0 + 6));
        cmp(q[n], 0);
        // Mode change, selection write, threshold write, convert with mode change.
        for (n = 0; n < 4; n++)
        begin
            cfg.conversion_mode_bit = 1'b1;
            pinfall();
            tick(50);
            cfg.conversion_mode_bit = (n != 0);
            strobe(hw[n]);
            q.delete();
            tick(300);
            cmp(q.size(), 0);
        end
        for (n = 0; n < 4; n++)
        begin
            fault = (n == 1) ? 6'h3f : 6'(rnd());
            tick(4);
            cmp(aflags, fault);
            cmp(alarm_n, ~|fault);
        end
        finish_test();
    end
endmodule : adc_sequence_control_test
